// [src/core_state_params.svh]
`ifndef CORE_STATE_PARAMS_SVH
`define CORE_STATE_PARAMS_SVH
// ============================================================
// register map and layout
`define REG_COUNT 32
`define PTR_X_ADDR 5'h1a
`define PTR_Y_ADDR 5'h1c
`define PTR_Z_ADDR 5'h1e
`define IO_SP_LOW 6'h3d
`define IO_SP_HIGH 6'h3e
`define LAST_SRAM_ADDRESS 16'h08ff
`define BOOT_START 14'h3800
`define IRQ_COUNT 8
`define ENTRY_CYCLES 3'h4
`define RETURN_CYCLES 3'h4
`define GIE_BIT 7
`endif

// [src/core_state_pkg.sv]
`default_nettype none
package core_state_pkg;
  // ============================================================
  // sequencer states, stack actions and pointer modes
  typedef enum logic [2:0] {seq_run, seq_entry, seq_return, seq_hold} seq_state_t;
  typedef enum logic [2:0] {sp_none, sp_push1, sp_push2, sp_pop1, sp_pop2} sp_op_t;
  typedef enum logic [1:0] {ptr_plain, ptr_postinc, ptr_predec, ptr_disp} ptr_mode_t;
endpackage : core_state_pkg
`default_nettype wire

// [src/working_reg_mem.sv]
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"
module working_reg_mem (
  input wire logic clock, // core clock
  input wire logic resetn, // sync reset, active low
  input wire logic [4:0] rd_a_addr, // operand a index
  input wire logic [4:0] rd_b_addr, // operand b index
  output logic [7:0] rd_a_data, // operand a, combinational
  output logic [7:0] rd_b_data, // operand b, combinational
  input wire logic wr_en, // byte write strobe
  input wire logic wr_word, // write 16 bits to pair
  input wire logic [4:0] wr_addr, // destination index
  input wire logic [15:0] wr_data, // result word
  output logic [15:0] ptr_x, // pointer pair at 0x1a
  output logic [15:0] ptr_y, // pointer pair at 0x1c
  output logic [15:0] ptr_z // pointer pair at 0x1e
);
  typedef struct packed {logic [31:0][7:0] r;} mem_state_t;
  mem_state_t s_q, s_d;
  // ============================================================
  // reads are combinational so one-cycle alu works
  assign rd_a_data = s_q.r[rd_a_addr];
  assign rd_b_data = s_q.r[rd_b_addr];
  assign ptr_x = {s_q.r[5'h1b], s_q.r[`PTR_X_ADDR]};
  assign ptr_y = {s_q.r[5'h1d], s_q.r[`PTR_Y_ADDR]};
  assign ptr_z = {s_q.r[5'h1f], s_q.r[`PTR_Z_ADDR]};
  // byte write or word write to an even-aligned pair
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      if (wr_word) begin
        s_d.r[{wr_addr[4:1], 1'b0}] = wr_data[7:0];
        s_d.r[{wr_addr[4:1], 1'b1}] = wr_data[15:8];
      end else begin
        s_d.r[wr_addr] = wr_data[7:0];
      end
    end
  end
  // ============================================================
  always_ff @(posedge clock) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
  end
endmodule : working_reg_mem
`default_nettype wire

// [src/irq_arbiter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"
module irq_arbiter (
  input wire logic clock, // core clock
  input wire logic resetn, // sync reset, active low
  input wire logic [7:0] flag_set, // flag-type event pulses, async
  input wire logic [7:0] level_req, // level-type conditions, async
  input wire logic [7:0] is_level, // source kind per bit
  input wire logic [7:0] enable, // individual enables
  input wire logic [7:0] flag_clr_w1, // software write-one clear
  input wire logic take, // vector taken this cycle
  input wire logic [2:0] take_idx, // source being taken
  output logic req_any, // some enabled source wants service
  output logic [2:0] req_idx, // highest priority index
  output logic [7:0] flags // pending flags
);
  typedef struct packed {logic [7:0] s1, s2, lv1, lv2, fl;} arb_state_t;
  arb_state_t s_q, s_d;
  logic [7:0] want;
  // ============================================================
  // synchronise pins; flag set beats clear in the same cycle
  always_comb begin
    s_d = s_q;
    s_d.s1 = flag_set;
    s_d.s2 = s_q.s1;
    s_d.lv1 = level_req;
    s_d.lv2 = s_q.lv1;
    for (int i = 0; i < `IRQ_COUNT; i++) begin
      if (flag_clr_w1[i] || (take && take_idx == 3'(i))) s_d.fl[i] = 1'b0;
      if (s_q.s2[i] && !is_level[i]) s_d.fl[i] = 1'b1;
    end
  end
  // level sources bypass latching entirely
  assign want = ((is_level & s_q.lv2) | (~is_level & s_q.fl)) & enable;
  assign flags = s_q.fl;
  // lowest index wins: vector order is priority order
  always_comb begin
    req_idx = 3'h0;
    for (int i = `IRQ_COUNT - 1; i >= 0; i--) begin
      if (want[i]) req_idx = 3'(i);
    end
  end
  assign req_any = |want;
  // ============================================================
  always_ff @(posedge clock) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
  end
endmodule : irq_arbiter
`default_nettype wire

// [src/core_state.sv]
`timescale 1ns/1ps
`default_nettype none
`include "core_state_params.svh"
module core_state (
  input wire logic clock, // core clock, 10 MHz
  input wire logic resetn, // sync reset, active low
  // register file port from decode
  input wire logic [4:0] rd_a_addr, // operand a index
  input wire logic [4:0] rd_b_addr, // operand b index
  output logic [7:0] rd_a_data, // operand a
  output logic [7:0] rd_b_data, // operand b
  input wire logic rf_wr_en, // result write strobe
  input wire logic rf_wr_word, // 16-bit result
  input wire logic [4:0] rf_wr_addr, // destination
  input wire logic [15:0] rf_wr_data, // result
  // pointer addressing
  input wire logic ptr_req, // indirect access this cycle
  input wire logic [1:0] ptr_sel, // 0 x, 1 y, 2 z
  input wire logic [1:0] ptr_mode, // ptr_mode_t
  input wire logic [5:0] ptr_disp, // displacement
  output logic [15:0] ptr_addr, // effective data address
  output logic ptr_is_reg, // address hits register file
  // data-space access to registers and sp
  input wire logic ds_wr, // data-space write strobe
  input wire logic [15:0] ds_addr, // data address
  input wire logic [7:0] ds_wdata, // write data
  output logic [7:0] ds_rdata, // read data, registered
  output logic ds_hit, // address is ours
  // stack ops from decode
  input wire logic [2:0] sp_op, // sp_op_t
  input wire logic [15:0] pc, // current program counter
  output logic [15:0] stack_ptr, // sp value
  // status bit control
  input wire logic gie_set_op, // set global enable
  input wire logic gie_clr_op, // clear global enable
  input wire logic return_from_irq_op_op, // return_from_irq_op
  input wire logic insn_done, // an instruction completes
  input wire logic sleeping, // core asleep
  // interrupt sources
  input wire logic [7:0] flag_set, // flag events
  input wire logic [7:0] level_req, // level conditions
  input wire logic [7:0] is_level, // source kinds
  input wire logic [7:0] irq_enable, // individual enables
  input wire logic [7:0] flag_clr_w1, // write-one clears
  output logic [7:0] irq_flags, // pending flags
  // vectors and boot lock
  input wire logic vector_select_bit, // from mcu_control_register
  input wire logic boot_reset_fuse, // programmed high
  input wire logic app_boot_lock_bit, // programmed high
  input wire logic boot_boot_lock_bit, // programmed high
  output logic [13:0] reset_vector, // reset fetch address
  output logic irq_entry, // entry sequence busy
  output logic [13:0] irq_vector, // vector to jump to, registered
  output logic vector_go, // vector fetch pulse
  output logic [7:0] sram_wdata, // push data to sram
  output logic sram_we, // push strobe
  output logic global_enable // gie bit of status_register
);
  typedef struct packed {
    core_state_pkg::seq_state_t st;
    logic [2:0] cnt;
    logic [15:0] sp;
    logic gie;
    logic hold;
    logic [2:0] idx;
    logic [13:0] vec;
    logic go;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic we;
  } core_t;
  core_t s_q, s_d;
  logic req_any;
  logic [2:0] req_idx;
  logic take;
  logic locked;
  logic [15:0] ptr_x, ptr_y, ptr_z, pbase;

  // decoding used by both read and write paths
  function automatic logic [1:0] io_decode(input logic [15:0] a);
    if (a == 16'h0020 + {10'h000, `IO_SP_LOW}) io_decode = 2'h1;
    else if (a == 16'h0020 + {10'h000, `IO_SP_HIGH}) io_decode = 2'h2;
    else if (a < 16'h0020) io_decode = 2'h3;
    else io_decode = 2'h0;
  endfunction : io_decode

  // ============================================================
  // working registers
  working_reg_mem u_regs (
    .clock(clock),
    .resetn(resetn),
    .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr),
    .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data),
    .wr_en(rf_wr_en || (ds_wr && io_decode(ds_addr) == 2'h3)),
    .wr_word(rf_wr_word && rf_wr_en),
    .wr_addr(rf_wr_en ? rf_wr_addr : ds_addr[4:0]),
    .wr_data(rf_wr_en ? rf_wr_data : {8'h00, ds_wdata}),
    .ptr_x(ptr_x),
    .ptr_y(ptr_y),
    .ptr_z(ptr_z)
  );

  // ============================================================
  // interrupt sources and priority
  irq_arbiter u_arb (
    .clock(clock),
    .resetn(resetn),
    .flag_set(flag_set),
    .level_req(level_req),
    .is_level(is_level),
    .enable(irq_enable),
    .flag_clr_w1(flag_clr_w1),
    .take(take),
    .take_idx(req_idx),
    .req_any(req_any),
    .req_idx(req_idx),
    .flags(irq_flags)
  );

  // ============================================================
  // pointer effective address; writeback of inc/dec left to decode
  always_comb begin
    case (ptr_sel)
      2'h0: pbase = ptr_x;
      2'h1: pbase = ptr_y;
      default: pbase = ptr_z;
    endcase
  end
  always_comb begin
    case (ptr_mode)
      2'h2: ptr_addr = pbase - 16'h0001;
      2'h3: ptr_addr = pbase + {10'h000, ptr_disp};
      default: ptr_addr = pbase;
    endcase
  end
  assign ptr_is_reg = ptr_req && (ptr_addr < 16'h0020);

  // boot lock bits may mask interrupts while running from application area (app) or boot area (boot)
  assign locked = (app_boot_lock_bit && pc[13:0] < `BOOT_START) ||
                  (boot_boot_lock_bit && pc[13:0] >= `BOOT_START);
  // clear op acts in same cycle, so a simultaneous request loses
  assign take = (s_q.st == core_state_pkg::seq_run) && s_q.gie && !gie_clr_op && !s_q.hold &&
                req_any && !locked && insn_done && !return_from_irq_op_op;
  assign reset_vector = boot_reset_fuse ? `BOOT_START : 14'h0000;

  // ============================================================
  // sequencer, stack pointer and global enable
  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.we = 1'b0;
    if (gie_set_op) begin
      s_d.gie = 1'b1;
      s_d.hold = 1'b1;
    end
    if (gie_clr_op) s_d.gie = 1'b0;
    if (insn_done && s_q.st == core_state_pkg::seq_run && !gie_set_op) s_d.hold = 1'b0;
    if (ds_wr && io_decode(ds_addr) == 2'h1) s_d.sp[7:0] = ds_wdata;
    if (ds_wr && io_decode(ds_addr) == 2'h2) s_d.sp[15:8] = ds_wdata;
    case (io_decode(ds_addr))
      2'h1: s_d.rdata = s_q.sp[7:0];
      2'h2: s_d.rdata = s_q.sp[15:8];
      default: s_d.rdata = 8'h00;
    endcase
    case (s_q.st)
      core_state_pkg::seq_run: begin
        case (core_state_pkg::sp_op_t'(sp_op))
          core_state_pkg::sp_push1: s_d.sp = s_q.sp - 16'h0001;
          core_state_pkg::sp_push2: s_d.sp = s_q.sp - 16'h0002;
          core_state_pkg::sp_pop1: s_d.sp = s_q.sp + 16'h0001;
          core_state_pkg::sp_pop2: s_d.sp = s_q.sp + 16'h0002;
          default: ;
        endcase
        if (return_from_irq_op_op) begin
          s_d.st = core_state_pkg::seq_return;
          s_d.cnt = `RETURN_CYCLES - 3'h1;
        end else if (take) begin
          s_d.st = core_state_pkg::seq_entry;
          s_d.cnt = sleeping ? 3'h7 : `ENTRY_CYCLES - 3'h1;
          s_d.gie = 1'b0;
          s_d.idx = req_idx;
        end
      end
      core_state_pkg::seq_entry: begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1 || s_q.cnt == 3'h2) begin
          s_d.we = 1'b1;
          s_d.wdata = (s_q.cnt == 3'h2) ? pc[7:0] : pc[15:8];
          s_d.sp = s_q.sp - 16'h0001;
        end
        if (s_q.cnt == 3'h0) begin
          s_d.st = core_state_pkg::seq_run;
          s_d.go = 1'b1;
          s_d.vec = (vector_select_bit ? `BOOT_START : 14'h0000) +
                    {10'h000, s_q.idx, 1'b0} + 14'h0002;
        end
      end
      core_state_pkg::seq_return: begin
        s_d.cnt = s_q.cnt - 3'h1;
        if (s_q.cnt == 3'h1 || s_q.cnt == 3'h2) s_d.sp = s_q.sp + 16'h0001;
        if (s_q.cnt == 3'h0) begin
          s_d.st = core_state_pkg::seq_run;
          s_d.gie = 1'b1;
          s_d.hold = 1'b1;
        end
      end
      default: s_d.st = core_state_pkg::seq_run;
    endcase
  end

  // ============================================================
  // outputs
  assign stack_ptr = s_q.sp;
  assign global_enable = s_q.gie;
  assign irq_entry = (s_q.st == core_state_pkg::seq_entry);
  assign irq_vector = s_q.vec;
  assign vector_go = s_q.go;
  assign ds_rdata = s_q.rdata;
  assign ds_hit = (io_decode(ds_addr) != 2'h0);
  assign sram_wdata = s_q.wdata;
  assign sram_we = s_q.we;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.sp <= `LAST_SRAM_ADDRESS;
      s_q.st <= core_state_pkg::seq_run;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : core_state
`default_nettype wire

// [testbench/core_state_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker on the core_state ports
module core_state_sva (
  input wire logic clock, // core clock
  input wire logic resetn, // sync reset, active low
  input wire logic [4:0] rd_a_addr, // operand a index
  input wire logic [7:0] rd_a_data, // operand a
  input wire logic rf_wr_en, // write strobe
  input wire logic rf_wr_word, // word write
  input wire logic [4:0] rf_wr_addr, // destination
  input wire logic [15:0] rf_wr_data, // result
  input wire logic ds_wr, // data-space write
  input wire logic [2:0] sp_op, // stack action
  input wire logic [15:0] pc, // program counter
  input wire logic [15:0] stack_ptr, // sp value
  input wire logic gie_clr_op, // clear global enable
  input wire logic return_from_irq_op_op, // return from irq
  input wire logic insn_done, // instruction completes
  input wire logic sleeping, // core asleep
  input wire logic app_boot_lock_bit, // application lock
  input wire logic irq_entry, // entry busy
  input wire logic vector_go, // vector pulse
  input wire logic sram_we, // push strobe
  input wire logic global_enable // gie bit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [15:0] sp_step;
  // expected sp change per stack action
  always_comb begin
    case (sp_op)
      3'h1: sp_step = 16'hffff;
      3'h2: sp_step = 16'hfffe;
      3'h3: sp_step = 16'h0001;
      default: sp_step = 16'h0002;
    endcase
  end
  property p_reset; $rose(resetn) |-> stack_ptr == 16'h08ff && !global_enable; endproperty
  a_reset: assert property (p_reset) else $error("sp or gie wrong after reset");
  // only plain cycles: entry, return and sp writes move sp on their own
  property p_sp_op; sp_op != 3'h0 && !ds_wr && !irq_entry && !insn_done && !return_from_irq_op_op
    |=> stack_ptr == $past(stack_ptr) + $past(sp_step); endproperty
  a_sp_op: assert property (p_sp_op) else $error("stack action moved sp wrongly");
  property p_walk; $rose(irq_entry) && !sleeping |-> ##2 sram_we ##1 sram_we ##1 vector_go; endproperty
  a_walk: assert property (p_walk) else $error("entry sequence timing wrong");
  // wake from sleep stretches entry by four cycles
  property p_sleep_walk; $rose(irq_entry) && sleeping |-> ##6 sram_we ##1 sram_we ##1 vector_go; endproperty
  a_sleep_walk: assert property (p_sleep_walk) else $error("sleep entry timing wrong");
  property p_entry_sp; $rose(irq_entry) && !sleeping |-> ##5 stack_ptr == $past(stack_ptr, 5) - 16'h0002;
  endproperty
  a_entry_sp: assert property (p_entry_sp) else $error("entry did not lower sp by two");
  property p_sleep_sp; $rose(irq_entry) && sleeping |-> ##9 stack_ptr == $past(stack_ptr, 9) - 16'h0002;
  endproperty
  a_sleep_sp: assert property (p_sleep_sp) else $error("sleep entry did not lower sp by two");
  property p_entry_gie; $rose(irq_entry) |-> !global_enable && $past(global_enable); endproperty
  a_entry_gie: assert property (p_entry_gie) else $error("entry gie handling wrong");
  property p_cli; gie_clr_op && !irq_entry |=> !irq_entry && !global_enable; endproperty
  a_cli: assert property (p_cli) else $error("irq taken after global disable");
  property p_wr; rf_wr_en && !rf_wr_word && !ds_wr |=> rd_a_addr != $past(rf_wr_addr) ||
    {8'h00, rd_a_data} == ($past(rf_wr_data) & 16'h00ff); endproperty
  a_wr: assert property (p_wr) else $error("byte result not read back next cycle");
  property p_return_from_irq_op; return_from_irq_op_op && !irq_entry |-> ##5 global_enable && stack_ptr == $past(stack_ptr, 5) + 16'h0002;
  endproperty
  a_return_from_irq_op: assert property (p_return_from_irq_op) else $error("return did not restore sp and gie");
  property p_lock; !irq_entry && app_boot_lock_bit && pc[13:0] < 14'h3800 |=> !irq_entry; endproperty
  a_lock: assert property (p_lock) else $error("irq taken under application lock");
  c_entry: cover property ($rose(irq_entry));
  c_return_from_irq_op: cover property (return_from_irq_op_op);
  c_cli: cover property (gie_clr_op && insn_done);
  c_push2: cover property (sp_op == 3'h2);
endmodule : core_state_sva
bind core_state core_state_sva u_sva (.*);
`default_nettype wire

// [testbench/irq_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// peripheral interrupt sources, driven off the falling edge
module irq_source_model (
  input wire logic clock, // core clock
  output logic [7:0] flag_set, // event pulses
  output logic [7:0] level_req // level conditions
);
  initial begin
    flag_set = 8'h00;
    level_req = 8'h00;
  end
  // one-cycle event, long enough for the two-stage synchroniser
  task automatic pulse(input logic [7:0] mask);
    @(negedge clock);
    flag_set = mask;
    @(negedge clock);
    flag_set = 8'h00;
  endtask : pulse
  // condition that vanishes again; a level source must not latch it
  task automatic level(input logic [7:0] mask, input int n);
    @(negedge clock);
    level_req = mask;
    repeat (n) @(negedge clock);
    level_req = 8'h00;
  endtask : level
endmodule : irq_source_model
`default_nettype wire

// [testbench/core_state_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module core_state_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00, rf_wr_addr = 5'h00, a;
  logic rf_wr_en = 1'b0, rf_wr_word = 1'b0, ptr_req = 1'b0, ds_wr = 1'b0, sleeping = 1'b0;
  logic [15:0] rf_wr_data = 16'h0000, ds_addr = 16'h0000, pc = 16'h0000, d, e;
  logic [1:0] ptr_sel = 2'h0, ptr_mode = 2'h0, s;
  logic [5:0] ptr_disp = 6'h00;
  logic [7:0] ds_wdata = 8'h00, is_level = 8'h40, irq_enable = 8'h00, flag_clr_w1 = 8'h00;
  logic [2:0] sp_op = 3'h0;
  logic gie_set_op = 1'b0, gie_clr_op = 1'b0, return_from_irq_op_op = 1'b0, insn_done = 1'b0;
  logic vector_select_bit = 1'b0, boot_reset_fuse = 1'b0, app_boot_lock_bit = 1'b0, boot_boot_lock_bit = 1'b0;
  logic [7:0] rd_a_data, rd_b_data, ds_rdata, irq_flags, sram_wdata, flag_set, level_req, lo, hi;
  logic [15:0] ptr_addr, stack_ptr;
  logic [13:0] reset_vector, irq_vector;
  logic ptr_is_reg, ds_hit, irq_entry, vector_go, sram_we, global_enable;
  int num_errors = 0, checked = 0, seed = 32'hfd66;
  core_state DUT (.*);
  irq_source_model src (.*);
  // 10 MHz core clock
  always #50 clock = ~clock;
  // ============================================================
  // shared tasks and expectations
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask : step
  task automatic insn;
    insn_done = 1'b1;
    step(1);
    insn_done = 1'b0;
  endtask : insn
  // bounded wait for the vector, collecting pushed bytes in order
  task automatic wait_vec(output logic [7:0] lo, output logic [7:0] hi);
    for (int n = 0; vector_go !== 1'b1; n++) begin
      if (sram_we === 1'b1) begin
        lo = hi;
        hi = sram_wdata;
      end
      if (n > 40) begin
        num_errors++;
        results();
      end
      step(1);
    end
  endtask : wait_vec
  task automatic ds_word(input logic [15:0] adr, input logic [15:0] v);
    ds_wr = 1'b1;
    ds_addr = adr;
    ds_wdata = v[7:0];
    step(1);
    ds_addr = adr + 16'h0001;
    ds_wdata = v[15:8];
    step(1);
    ds_wr = 1'b0;
  endtask : ds_word
  function automatic logic [13:0] vec(input logic sel, input logic [2:0] idx);
    return (sel ? 14'h3800 : 14'h0000) + {10'h000, idx, 1'b0} + 14'h0002;
  endfunction : vec
  function automatic logic [15:0] sp_step(input logic [2:0] k);
    return (k == 3'h1) ? 16'hffff : (k == 3'h2) ? 16'hfffe : (k == 3'h3) ? 16'h0001 : 16'h0002;
  endfunction : sp_step
  // ============================================================
  // main sequence
  initial begin
    step(2);
    resetn = 1'b1;
    chk("stack_ptr", stack_ptr, 16'h08ff);
    chk("global_enable", global_enable, 16'h0000);
    boot_reset_fuse = 1'b1;
    #1 chk("reset_vector", reset_vector, 16'h3800);
    // byte writes on even steps, word writes to a pair on odd ones
    for (int i = 0; i < 8; i++) begin
      a = 5'($random(seed));
      d = 16'($random(seed));
      rf_wr_addr = a;
      rf_wr_data = d;
      rf_wr_word = i[0];
      rf_wr_en = 1'b1;
      rd_a_addr = i[0] ? {a[4:1], 1'b0} : a;
      rd_b_addr = i[0] ? {a[4:1], 1'b1} : a;
      step(1);
      rf_wr_en = 1'b0;
      chk("rd_a_data", rd_a_data, d & 16'h00ff);
      chk("rd_b_data", rd_b_data, i[0] ? d >> 8 : d & 16'h00ff);
    end
    // pointers loaded through data space, one mode each; first points into the file
    for (int m = 0; m < 4; m++) begin
      s = 2'(m % 3);
      d = (m == 0) ? 16'h0010 : 16'($random(seed));
      ds_word(16'h001a + {13'h0000, s, 1'b0}, d);
      ptr_req = 1'b1;
      ptr_sel = s;
      ptr_mode = 2'(m);
      ptr_disp = 6'($random(seed));
      e = (m == 2) ? d - 16'h0001 : (m == 3) ? d + {10'h000, ptr_disp} : d;
      #1 chk("ptr_addr", ptr_addr, e);
      chk("ptr_is_reg", ptr_is_reg, e < 16'h0020);
      step(1);
      ptr_req = 1'b0;
    end
    e = {8'h08, 8'($random(seed))};
    ds_word(16'h005d, e);
    chk("stack_ptr", stack_ptr, e);
    ds_addr = 16'h005e;
    step(1);
    chk("ds_rdata", ds_rdata, e >> 8);
    chk("ds_hit", ds_hit, 16'h0001);
    for (int k = 1; k <= 4; k++) begin
      sp_op = 3'(k);
      step(1);
      sp_op = 3'h0;
      e = e + sp_step(3'(k));
      chk("stack_ptr", stack_ptr, e);
    end
    // two flags and a passing level condition while gie is off
    irq_enable = 8'hff;
    pc = {3'h0, 13'($random(seed))};
    src.pulse(8'h24);
    src.level(8'h40, 2);
    step(4);
    chk("irq_flags", irq_flags & 8'h24, 16'h0024);
    gie_set_op = 1'b1;
    step(1);
    gie_set_op = 1'b0;
    insn();
    chk("irq_entry", irq_entry, 16'h0000);
    lo = 8'h00;
    hi = 8'h00;
    insn();
    wait_vec(lo, hi);
    chk("irq_vector", irq_vector, vec(1'b0, 3'h2));
    chk("global_enable", global_enable, 16'h0000);
    chk("irq_flags", irq_flags & 8'h04, 16'h0000);
    chk("pushed_pc", {hi, lo}, pc);
    step(1);
    chk("stack_ptr", stack_ptr, e - 16'h0002);
    for (int r = 0; r < 2; r++) begin
      return_from_irq_op_op = 1'b1;
      step(1);
      return_from_irq_op_op = 1'b0;
      step(5);
      chk("global_enable", global_enable, 16'h0001);
      chk("stack_ptr", stack_ptr, e);
      if (r == 0) begin
        insn();
        chk("irq_entry", irq_entry, 16'h0000);
        vector_select_bit = 1'b1;
        insn();
        wait_vec(lo, hi);
        chk("irq_vector", irq_vector, vec(1'b1, 3'h5));
      end
    end
    // pending flag meets a global disable in the same cycle
    src.pulse(8'h01);
    step(3);
    insn();
    gie_clr_op = 1'b1;
    insn();
    gie_clr_op = 1'b0;
    chk("irq_entry", irq_entry, 16'h0000);
    app_boot_lock_bit = 1'b1;
    gie_set_op = 1'b1;
    step(1);
    gie_set_op = 1'b0;
    insn();
    insn();
    chk("irq_entry", irq_entry, 16'h0000);
    pc = 16'h3900;
    sleeping = 1'b1;
    insn();
    step(5);
    chk("vector_go", vector_go, 16'h0000);
    wait_vec(lo, hi);
    sleeping = 1'b0;
    chk("irq_vector", irq_vector, vec(1'b1, 3'h0));
    chk("pushed_pc", {hi, lo}, 16'h3900);
    src.pulse(8'h80);
    step(3);
    flag_clr_w1 = 8'h80;
    step(1);
    flag_clr_w1 = 8'h00;
    step(1);
    chk("irq_flags", irq_flags, 16'h0000);
    results();
  end
endmodule : core_state_tb
`default_nettype wire
